//--- design/acc_params.svh
// constants for the converter conversion control block
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define ACC_CLK_PERIOD_NS 4
`define ACC_ACQ_TIME_NS   100
`define ACC_ACQ_CYCLES    ((`ACC_ACQ_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_STEP_CYCLES   4
`define ACC_ACQ_W         8
`define ACC_STEP_W        4
// ------------------------------------------------------------
// result layout
// ------------------------------------------------------------
`define ACC_RES_W         16
`define ACC_MSB_IDX       4'hF
`define ACC_MSB_CODE      16'h8000
// ------------------------------------------------------------
// register offsets and fields
// ------------------------------------------------------------
`define ACC_OFS_CTRL      8'h00
`define ACC_OFS_STATUS    8'h04
`define ACC_OFS_RESULT    8'h08
`define ACC_OFS_IRQ_STAT  8'h0C
`define ACC_OFS_IRQ_MASK  8'h10
`define ACC_CTRL_RESET    1'h0
`define ACC_IRQ_W         2
`define ACC_IRQ_DONE      0
`define ACC_IRQ_START     1
`define ACC_IRQ_RESET     2'h0
`endif

//--- design/acc_pkg.sv
// types of the converter conversion control block
package acc_pkg;
  // gray coded along acquire, wait, convert, latch
  typedef enum logic [2:0] {
    ACC_S_ACQ   = 3'h0,
    ACC_S_WAIT  = 3'h1,
    ACC_S_CONV  = 3'h3,
    ACC_S_LATCH = 3'h2,
    ACC_S_SLEEP = 3'h6
  } acc_state_t;
endpackage : acc_pkg

//--- design/acc_conversion_control.sv
// conversion control of a successive approximation converter with ahb-lite registers
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "acc_params.svh"
module acc_conversion_control
  import acc_pkg::*;
(
  input  wire logic                   REF_CLK,
  input  wire logic                   ARST_N,
  input  wire logic                   HSEL,
  input  wire logic [31:0]            HADDR,
  input  wire logic [1:0]             HTRANS,
  input  wire logic                   HWRITE,
  input  wire logic [2:0]             HSIZE,
  input  wire logic [31:0]            HWDATA,
  input  wire logic                   HREADY,
  output logic                        HREADYOUT,
  output logic                        HRESP,
  output logic [31:0]                 HRDATA,
  input  wire logic                   CONVERT_START_N,
  input  wire logic                   CONV_RESET,
  input  wire logic                   SLEEP_REQUEST,
  input  wire logic                   CS_N,
  input  wire logic                   RD_N,
  input  wire logic                   SCLK_IN,
  input  wire logic                   COMP_IN,
  output logic                        BUSY,
  output logic                        SAMPLE_HOLD,
  output logic                        LOW_POWER,
  output logic [`ACC_RES_W-1:0]       DAC_CODE,
  output logic [`ACC_RES_W-1:0]       PAR_DATA,
  output logic                        PAR_OE,
  output logic                        SDOUT,
  output logic                        SDOUT_OE,
  output logic                        IRQ
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  acc_state_t                 state;
  acc_state_t                 next_state;
  logic [`ACC_ACQ_W-1:0]      acq_cnt;
  logic [`ACC_STEP_W-1:0]     step_cnt;
  logic [3:0]                 bit_idx;
  logic [`ACC_RES_W-1:0]      code;
  logic [`ACC_RES_W-1:0]      shift_reg;
  logic [`ACC_RES_W-1:0]      result;
  logic                       busy;
  logic                       hold;
  logic                       low_power;
  logic                       start_prev;
  logic                       sclk_prev;
  logic                       serial_mode;
  logic [`ACC_IRQ_W-1:0]      irq_stat;
  logic [`ACC_IRQ_W-1:0]      irq_mask;
  logic [`ACC_IRQ_W-1:0]      irq_event;
  logic                       acq_done;
  logic                       step_done;
  logic                       start_fall;
  logic                       conv_begin;
  logic                       sclk_rise;
  logic                       bus_oe;
  logic                       ap_valid;
  logic                       ap_read;
  logic                       dp_write;
  logic [7:0]                 dp_addr;
  logic [31:0]                rd_value;

  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] ofs);
    reg_hit = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
  endfunction : reg_hit

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  assign acq_done   = (acq_cnt == `ACC_ACQ_W'(`ACC_ACQ_CYCLES - 1));
  assign step_done  = (step_cnt == `ACC_STEP_W'(`ACC_STEP_CYCLES - 1));
  assign start_fall = start_prev && !CONVERT_START_N;
  assign conv_begin = (next_state == ACC_S_CONV) && (state != ACC_S_CONV);

  always_comb begin
    next_state = state;
    case (state)
      ACC_S_ACQ: begin
        if (SLEEP_REQUEST) begin
          next_state = ACC_S_SLEEP;
        end else if (acq_done) begin
          if (!CONVERT_START_N) begin
            next_state = ACC_S_CONV;
          end else begin
            next_state = ACC_S_WAIT;
          end
        end
      end
      ACC_S_WAIT: begin
        if (SLEEP_REQUEST) begin
          next_state = ACC_S_SLEEP;
        end else if (start_fall) begin
          next_state = ACC_S_CONV;
        end
      end
      ACC_S_CONV: begin
        if (step_done && (bit_idx == 4'h0)) begin
          next_state = ACC_S_LATCH;
        end
      end
      ACC_S_LATCH: begin
        next_state = SLEEP_REQUEST ? ACC_S_SLEEP : ACC_S_ACQ;
      end
      ACC_S_SLEEP: begin
        if (!SLEEP_REQUEST) begin
          next_state = ACC_S_ACQ;
        end
      end
      default: begin
        next_state = ACC_S_ACQ;
      end
    endcase
    if (CONV_RESET) begin
      next_state = ACC_S_ACQ;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ACC_S_ACQ;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      acq_cnt    <= '0;
      start_prev <= 1'b1;
    end else begin
      start_prev <= CONVERT_START_N;
      if (CONV_RESET || state != ACC_S_ACQ) begin
        acq_cnt <= '0;
      end else if (next_state == ACC_S_ACQ && !acq_done) begin
        acq_cnt <= acq_cnt + `ACC_ACQ_W'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // successive approximation
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      code     <= '0;
      bit_idx  <= 4'h0;
      step_cnt <= '0;
    end else if (conv_begin) begin
      code     <= `ACC_MSB_CODE;
      bit_idx  <= `ACC_MSB_IDX;
      step_cnt <= '0;
    end else if (state == ACC_S_CONV && !CONV_RESET) begin
      step_cnt <= step_done ? '0 : step_cnt + `ACC_STEP_W'(1);
      if (step_done) begin
        if (!COMP_IN) begin
          code[bit_idx] <= 1'b0;
        end
        if (bit_idx != 4'h0) begin
          code[bit_idx - 4'h1] <= 1'b1;
          bit_idx              <= bit_idx - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy      <= 1'b0;
      hold      <= 1'b0;
      low_power <= 1'b0;
    end else begin
      hold      <= (next_state == ACC_S_CONV);
      low_power <= (next_state == ACC_S_SLEEP);
      if (CONV_RESET) begin
        busy <= 1'b0;
      end else if (conv_begin) begin
        busy <= 1'b1;
      end else if (state == ACC_S_LATCH) begin
        busy <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // output shift register and bus enables
  // ------------------------------------------------------------
  assign sclk_rise = SCLK_IN && !sclk_prev && !CS_N;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      shift_reg <= '0;
      result    <= '0;
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= SCLK_IN;
      if (state == ACC_S_LATCH && !CONV_RESET) begin
        shift_reg <= code;
        result    <= code;
      end else if (serial_mode && sclk_rise) begin
        shift_reg <= {shift_reg[`ACC_RES_W-2:0], 1'b0};
      end
    end
  end

  assign bus_oe      = !CS_N && !RD_N;
  assign PAR_OE      = bus_oe && !serial_mode;
  assign SDOUT_OE    = bus_oe && serial_mode;
  assign PAR_DATA    = shift_reg;
  assign SDOUT       = shift_reg[`ACC_RES_W-1];
  assign BUSY        = busy;
  assign SAMPLE_HOLD = hold;
  assign LOW_POWER   = low_power;
  assign DAC_CODE    = code;

  // ------------------------------------------------------------
  // ahb-lite register slave
  // ------------------------------------------------------------
  assign ap_valid  = HSEL && HTRANS[1] && HREADY;
  assign ap_read   = ap_valid && !HWRITE;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  always_comb begin
    rd_value = 32'h00000000;
    if (reg_hit(HADDR, `ACC_OFS_CTRL)) begin
      rd_value = {31'h00000000, serial_mode};
    end else if (reg_hit(HADDR, `ACC_OFS_STATUS)) begin
      rd_value = {27'h0000000, state, low_power, busy};
    end else if (reg_hit(HADDR, `ACC_OFS_RESULT)) begin
      rd_value = {16'h0000, result};
    end else if (reg_hit(HADDR, `ACC_OFS_IRQ_STAT)) begin
      rd_value = {30'h00000000, irq_stat};
    end else if (reg_hit(HADDR, `ACC_OFS_IRQ_MASK)) begin
      rd_value = {30'h00000000, irq_mask};
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
      HRDATA   <= 32'h00000000;
    end else begin
      dp_write <= ap_valid && HWRITE && (HADDR[31:8] == 24'h000000);
      dp_addr  <= HADDR[7:0];
      if (ap_read) begin
        HRDATA <= rd_value;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      serial_mode <= `ACC_CTRL_RESET;
      irq_mask    <= `ACC_IRQ_RESET;
    end else if (dp_write) begin
      if (dp_addr == `ACC_OFS_CTRL) begin
        serial_mode <= HWDATA[0];
      end
      if (dp_addr == `ACC_OFS_IRQ_MASK) begin
        irq_mask <= HWDATA[`ACC_IRQ_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  assign irq_event[`ACC_IRQ_DONE]  = (state == ACC_S_LATCH) && !CONV_RESET;
  assign irq_event[`ACC_IRQ_START] = conv_begin;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_stat <= `ACC_IRQ_RESET;
    end else if (ap_read && reg_hit(HADDR, `ACC_OFS_IRQ_STAT)) begin
      irq_stat <= irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  assign IRQ = |(irq_stat & irq_mask);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  property p_busy_rise;
    $rose(busy) |-> (state == ACC_S_CONV) && hold;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy rose outside conversion");

  property p_busy_fall;
    $fell(busy) && !$past(CONV_RESET) |-> $past(state) == ACC_S_LATCH && shift_reg == result;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy fell before result capture");

  property p_bus_enable;
    (PAR_OE || SDOUT_OE) |-> !CS_N && !RD_N && !(PAR_OE && SDOUT_OE);
  endproperty
  a_bus_enable: assert property (p_bus_enable) else $error("bus driven without select and read");

  property p_bus_release;
    (CS_N || RD_N) |-> !PAR_OE && !SDOUT_OE;
  endproperty
  a_bus_release: assert property (p_bus_release) else $error("bus not released");

  property p_sclk_gate;
    CS_N && state != ACC_S_LATCH |=> $stable(shift_reg);
  endproperty
  a_sclk_gate: assert property (p_sclk_gate) else $error("shift while deselected");

  property p_reset_abort;
    CONV_RESET |=> state == ACC_S_ACQ && !busy && acq_cnt == '0;
  endproperty
  a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");

  property p_sleep_finish;
    SLEEP_REQUEST && !CONV_RESET && state == ACC_S_CONV |=> state inside {ACC_S_CONV, ACC_S_LATCH};
  endproperty
  a_sleep_finish: assert property (p_sleep_finish) else $error("sleep cut a conversion");

  property p_sleep_hold;
    state == ACC_S_SLEEP && SLEEP_REQUEST && !CONV_RESET |=> state == ACC_S_SLEEP && !busy;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("conversion during sleep");

  property p_wait_edge;
    state == ACC_S_WAIT && !CONV_RESET && !SLEEP_REQUEST |=> (busy == $past(start_fall));
  endproperty
  a_wait_edge: assert property (p_wait_edge) else $error("wait state ignored start edge rule");

  property p_start_low;
    state == ACC_S_ACQ && acq_done && !CONVERT_START_N && !CONV_RESET && !SLEEP_REQUEST
      |=> state == ACC_S_CONV ##1 busy;
  endproperty
  a_start_low: assert property (p_start_low) else $error("low start did not convert");

  property p_busy_ignore;
    state == ACC_S_LATCH && !CONV_RESET |=> state inside {ACC_S_ACQ, ACC_S_SLEEP} && !busy;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("start acted on before acquisition");

endmodule : acc_conversion_control

//--- sim/acc_host_model.sv
// host side model: comparator front end and data ready capture
`timescale 1ns/1ns
module acc_host_model #(
  parameter logic [15:0] ANALOG = 16'hA5C3
) (
  input  wire logic        REF_CLK,
  input  wire logic        BUSY,
  input  wire logic [15:0] DAC_CODE,
  input  wire logic [15:0] PAR_DATA,
  output logic             COMP_IN,
  output logic [15:0]      ready_data
);
  logic busy_q = 1'b0;
  // ------------------------------------------------------------
  // comparator and result capture
  // ------------------------------------------------------------
  assign COMP_IN = (ANALOG >= DAC_CODE);
  always @(posedge REF_CLK) begin
    busy_q <= BUSY;
    if (busy_q === 1'b1 && BUSY === 1'b0) begin
      ready_data <= PAR_DATA;
    end
  end
endmodule : acc_host_model

//--- sim/tb_acc_conversion_control.sv
// self-checking bench of the conversion control block
`timescale 1ns/1ns
`include "acc_params.svh"
module tb_acc_conversion_control;
  import acc_pkg::*;
  localparam logic [15:0] ANALOG = 16'hA5C3;
  logic REF_CLK = 1'b0, ARST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic CONVERT_START_N = 1'b0, CONV_RESET = 1'b0, SLEEP_REQUEST = 1'b0;
  logic CS_N = 1'b1, RD_N = 1'b1, SCLK_IN = 1'b0;
  wire logic HREADYOUT, HRESP, COMP_IN, BUSY, SAMPLE_HOLD, LOW_POWER;
  wire logic PAR_OE, SDOUT, SDOUT_OE, IRQ;
  wire logic [31:0] HRDATA;
  wire logic [15:0] DAC_CODE, PAR_DATA, ready_data;
  int mismatches = 0, checks = 0, cycles = 0, n;
  logic [31:0] rd;
  always #2 REF_CLK = ~REF_CLK;
  acc_conversion_control acc_conversion_control_inst (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .CONVERT_START_N(CONVERT_START_N), .CONV_RESET(CONV_RESET),
    .SLEEP_REQUEST(SLEEP_REQUEST), .CS_N(CS_N), .RD_N(RD_N), .SCLK_IN(SCLK_IN),
    .COMP_IN(COMP_IN), .BUSY(BUSY), .SAMPLE_HOLD(SAMPLE_HOLD),
    .LOW_POWER(LOW_POWER), .DAC_CODE(DAC_CODE), .PAR_DATA(PAR_DATA),
    .PAR_OE(PAR_OE), .SDOUT(SDOUT), .SDOUT_OE(SDOUT_OE), .IRQ(IRQ));
  acc_host_model #(.ANALOG(ANALOG)) acc_host_model_inst (
    .REF_CLK(REF_CLK), .BUSY(BUSY), .DAC_CODE(DAC_CODE), .PAR_DATA(PAR_DATA),
    .COMP_IN(COMP_IN), .ready_data(ready_data));
  // ------------------------------------------------------------
  // report, checks and timeout
  // ------------------------------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  always @(posedge REF_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end
  // ------------------------------------------------------------
  // bus and timing helpers
  // ------------------------------------------------------------
  task tick;
    @(posedge REF_CLK);
    #1;
  endtask : tick
  task wait_rdy;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) @(posedge REF_CLK);
  endtask : wait_rdy
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= wr;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
    rd = HRDATA;
  endtask : ahb
  task wait_level(input logic lvl);
    while (BUSY !== lvl) tick();
  endtask : wait_level
  task run_len(input logic lvl, output int len);
    len = 0;
    while (BUSY === lvl && len < 300) begin
      len++;
      tick();
    end
  endtask : run_len
  task drive_sel(input logic cs, input logic rdn);
    @(posedge REF_CLK);
    CS_N <= cs;
    RD_N <= rdn;
    tick();
  endtask : drive_sel
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    tick();
    check("busy_rst", BUSY, 1'b0);
    check("hresp", HRESP, 1'b0);
    check("hreadyout", HREADYOUT, 1'b1);
    ahb(1'b0, {24'h0, `ACC_OFS_CTRL}, 32'h0);
    check("ctrl_rst", rd, 32'h0);
    ahb(1'b1, {24'h0, `ACC_OFS_IRQ_MASK}, 32'h3);
    ahb(1'b0, {24'h0, `ACC_OFS_IRQ_MASK}, 32'h0);
    check("mask", rd, 32'h3);
    ahb(1'b0, 32'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    wait_level(1'b1);
    wait_level(1'b0);
    run_len(1'b0, n);
    check("acq_gap", n, `ACC_ACQ_CYCLES);
    check("hold", SAMPLE_HOLD, 1'b1);
    run_len(1'b1, n);
    check("busy_len", n, 65);
    check("dac_code", DAC_CODE, ANALOG);
    check("ready_data", ready_data, ANALOG);
    check("irq_on", IRQ, 1'b1);
    ahb(1'b0, {24'h0, `ACC_OFS_RESULT}, 32'h0);
    check("result", rd, {16'h0, ANALOG});
    ahb(1'b0, {24'h0, `ACC_OFS_IRQ_STAT}, 32'h0);
    check("irq_stat", rd, 32'h3);
    tick();
    check("irq_off", IRQ, 1'b0);
    @(posedge REF_CLK) CONVERT_START_N <= 1'b1;
    repeat (60) tick();
    check("wait_edge", BUSY, 1'b0);
    @(posedge REF_CLK) CONVERT_START_N <= 1'b0;
    tick();
    run_len(1'b0, n);
    check("edge_start", n, 0);
    repeat (10) @(posedge REF_CLK);
    CONVERT_START_N <= 1'b1;
    repeat (10) @(posedge REF_CLK);
    CONVERT_START_N <= 1'b0;
    @(posedge REF_CLK) CONVERT_START_N <= 1'b1;
    wait_level(1'b0);
    repeat (60) tick();
    check("ignore_busy", BUSY, 1'b0);
    @(posedge REF_CLK) CONVERT_START_N <= 1'b0;
    wait_level(1'b1);
    ahb(1'b0, {24'h0, `ACC_OFS_IRQ_STAT}, 32'h0);
    @(posedge REF_CLK) CONV_RESET <= 1'b1;
    @(posedge REF_CLK) CONV_RESET <= 1'b0;
    tick();
    check("abort", BUSY, 1'b0);
    ahb(1'b0, {24'h0, `ACC_OFS_IRQ_STAT}, 32'h0);
    check("abort_irq", rd, 32'h0);
    wait_level(1'b1);
    @(posedge REF_CLK) SLEEP_REQUEST <= 1'b1;
    wait_level(1'b0);
    ahb(1'b0, {24'h0, `ACC_OFS_IRQ_STAT}, 32'h0);
    check("sleep_done", rd, 32'h3);
    repeat (40) tick();
    check("sleep_pwr", LOW_POWER, 1'b1);
    check("sleep_idle", BUSY, 1'b0);
    @(posedge REF_CLK) SLEEP_REQUEST <= 1'b0;
    wait_level(1'b1);
    check("wake", LOW_POWER, 1'b0);
    @(posedge REF_CLK) CONVERT_START_N <= 1'b1;
    wait_level(1'b0);
    drive_sel(1'b0, 1'b0);
    check("par_oe", PAR_OE, 1'b1);
    check("par_data", PAR_DATA, ANALOG);
    drive_sel(1'b0, 1'b1);
    check("par_rd_off", PAR_OE, 1'b0);
    drive_sel(1'b1, 1'b0);
    check("par_cs_off", PAR_OE, 1'b0);
    ahb(1'b1, {24'h0, `ACC_OFS_CTRL}, 32'h1);
    check("ser_cs_off", SDOUT_OE, 1'b0);
    @(posedge REF_CLK) SCLK_IN <= 1'b1;
    @(posedge REF_CLK) SCLK_IN <= 1'b0;
    tick();
    check("gated_sclk", SDOUT, ANALOG[15]);
    drive_sel(1'b0, 1'b0);
    check("ser_oe", SDOUT_OE, 1'b1);
    check("ser_par_off", PAR_OE, 1'b0);
    @(posedge REF_CLK) SCLK_IN <= 1'b1;
    @(posedge REF_CLK) SCLK_IN <= 1'b0;
    repeat (2) tick();
    check("shift", SDOUT, ANALOG[14]);
    summarize();
  end
endmodule : tb_acc_conversion_control
